// ### drive_safe_stop_sequencer.sv
// The placing of the registers and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
`include "dss_consts.svh"
module drive_safe_stop_sequencer
  import dss_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        cutoff_stop_request_in,
  input  wire logic        cutoff_stop_second_in,
  input  wire logic        hold_stop_request_in,
  input  wire logic        severe_fault_in,
  input  wire logic        stop_error_in,
  input  wire logic        torque_off_readback_in,
  input  wire amp_fb_t     amp_fb,
  output logic             torque_off_feedback_out,
  output logic             second_shutdown_out,
  output logic             ready_out,
  output logic             standstill_feedback_out,
  output logic             brake_command_out,
  output logic             emergency_ramp_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic fell(input logic prev, input logic cur);
    return prev & ~cur;
  endfunction

  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] data,
                                         input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = data[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] absdiff(input logic [31:0] a,
                                          input logic [31:0] b);
    return (a > b) ? (a - b) : (b - a);
  endfunction

  // Bits [1:0] are ignored, so any byte address inside a word hits that word
  function automatic logic [7:0] word_addr(input logic [7:0] a);
    return {a[7:2], 2'b00};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  state_t s;
  state_t n;

  logic cut_a;
  logic cut_b;
  logic both_low;
  logic cut_req;
  logic hold_req;
  logic hold_high;
  logic severe;
  logic err_rise;
  logic reset_req;
  logic toff_done;
  logic hold_done;
  logic at_still;
  logic ramp_bad;
  logic pos_out;
  logic drive_act;
  logic wr_go;

  // Only the second and third sync stages are decoded
  assign cut_a     = s.s2[`PIN_CUT_A];
  assign cut_b     = s.s2[`PIN_CUT_B];
  assign both_low  = ~cut_a & ~cut_b;
  assign cut_req   = fell(s.s3[`PIN_CUT_A], cut_a)
                   | fell(s.s3[`PIN_CUT_B], cut_b);
  assign hold_req  = fell(s.s3[`PIN_HOLD], s.s2[`PIN_HOLD]);
  assign hold_high = s.s2[`PIN_HOLD];
  assign severe    = s.s2[`PIN_SEVERE];
  assign err_rise  = s.s2[`PIN_ERR] & ~s.s3[`PIN_ERR];
  assign reset_req = fell(s.s2[`PIN_CUT_B], s.s3[`PIN_CUT_B]);
  assign toff_done = s.timer >= s.cfg.toff_dly;
  assign hold_done = s.timer >= s.cfg.hold_dly;
  assign at_still  = (s.cfg.still_thr != 32'h0000_0000)
                   && ({16'h0000, amp_fb.speed} < s.cfg.still_thr);
  assign ramp_bad  = s.cfg.ctrl[`CTRL_RAMP_MON]
                   && (amp_fb.ramp_err > s.cfg.pos_err_max);
  assign pos_out   = absdiff(amp_fb.position, s.hold_pos) > s.cfg.tol_win;
  assign drive_act = s.cfg.ctrl[`CTRL_DRIVE_ACT];
  assign wr_go     = s.aw_full & s.w_full & ~s.bvalid;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    n    = s;
    // Pins land in stage one; only stage two and the edge stage feed decisions
    n.s1 = {torque_off_readback_in, stop_error_in, severe_fault_in,
            hold_stop_request_in, cutoff_stop_second_in, cutoff_stop_request_in};
    n.s2 = s.s1;
    n.s3 = s.s2;

    unique case (s.mode)
      ST_BOOT: begin
        n.boot_cnt = s.boot_cnt + 8'h01;
        if (s.boot_cnt == `STARTUP_TICKS) begin
          n.mode = (both_low | ~cut_a | ~cut_b | severe) ? ST_TOFF : ST_RUN;
        end
      end
      ST_RUN, ST_HOLD, ST_MON: begin
        // Cutoff handling comes first in every running mode
        if (severe) begin
          n.mode = ST_TOFF;
        end else if (both_low) begin
          n.mode = ST_TOFF;
        end else if (cut_req | err_rise) begin
          n.estop = err_rise;
          n.timer = 32'h0000_0000;
          n.mode  = (s.cfg.toff_dly == 32'h0000_0000) ? ST_TOFF : ST_CUT;
        end else begin
          unique case (s.mode)
            ST_RUN: begin
              if (hold_req) begin
                n.timer = 32'h0000_0000;
                n.mode  = ST_HOLD;
              end
            end
            ST_HOLD: begin
              n.timer = s.timer + 32'h0000_0001;
              if (hold_high) begin
                n.mode = ST_RUN;
              end else if (hold_done | at_still) begin
                n.hold_pos = amp_fb.position;
                n.mode     = ST_MON;
              end
            end
            default: begin
              // A window breach escalates straight to the emergency cutoff ramp
              if (pos_out) begin
                n.estop = 1'b1;
                n.timer = 32'h0000_0000;
                n.mode  = ST_CUT;
              end else if (hold_high) begin
                n.mode = ST_RUN;
              end
            end
          endcase
        end
      end
      ST_CUT: begin
        // One input low keeps the delay running, both low ends it
        n.timer = s.timer + 32'h0000_0001;
        if (severe | both_low | err_rise) begin
          n.mode = ST_TOFF;
        end else if (toff_done) begin
          n.mode = ST_TOFF;
        end else if (ramp_bad) begin
          n.mode = ST_TOFF;
        end else if (at_still) begin
          n.mode = ST_TOFF;
        end
      end
      ST_TOFF: begin
        // Restart needs both inputs high and a fresh edge on the second
        if (cut_a & cut_b & reset_req & ~severe & ~s.fb_fault) begin
          n.estop = 1'b0;
          n.mode  = ST_RUN;
        end
      end
      default: begin
        n.mode = ST_TOFF;
      end
    endcase

    // Readback must follow the feedback output within a few ticks
    // Sticky: a broken feedback path must not heal itself without a reset
    if (s.s2[`PIN_RDBK] != s.torque_off && s.mode != ST_BOOT) begin
      if (s.fb_cnt == `FB_TICKS) begin
        n.fb_fault = 1'b1;
      end else begin
        n.fb_cnt = s.fb_cnt + 4'h1;
      end
    end else begin
      n.fb_cnt = 4'h0;
    end

    n.torque_off = (n.mode == ST_TOFF) | (n.mode == ST_BOOT);
    n.brake_cmd  = drive_act & ((n.mode == ST_CUT) | (n.mode == ST_HOLD));
    n.standstill = (n.mode == ST_MON);
    n.ready      = (n.mode != ST_BOOT) & ~severe & ~n.fb_fault;

    // AXI4-Lite write path: address and data taken in either order
    if (awvalid & ~s.aw_full) begin
      n.aw_full = 1'b1;
      n.aw_addr = awaddr;
    end
    if (wvalid & ~s.w_full) begin
      n.w_full = 1'b1;
      n.w_data = wdata;
      n.w_strb = wstrb;
    end
    if (s.bvalid & bready) begin
      n.bvalid = 1'b0;
    end
    if (wr_go) begin
      n.aw_full = 1'b0;
      n.w_full  = 1'b0;
      n.bvalid  = 1'b1;
      n.bresp   = `RESP_OKAY;
      unique case (word_addr(s.aw_addr))
        `ADDR_CTRL:      n.cfg.ctrl = wmerge(s.cfg.ctrl, s.w_data, s.w_strb)
                                      & `CTRL_MASK;
        `ADDR_TOFF_DLY:  n.cfg.toff_dly = wmerge(s.cfg.toff_dly, s.w_data, s.w_strb);
        `ADDR_HOLD_DLY:  n.cfg.hold_dly = wmerge(s.cfg.hold_dly, s.w_data, s.w_strb);
        `ADDR_STILL_THR: n.cfg.still_thr = wmerge(s.cfg.still_thr, s.w_data, s.w_strb);
        `ADDR_POS_ERR:   n.cfg.pos_err_max = wmerge(s.cfg.pos_err_max, s.w_data, s.w_strb);
        `ADDR_TOL_WIN:   n.cfg.tol_win = wmerge(s.cfg.tol_win, s.w_data, s.w_strb);
        `ADDR_STATUS:    n.bresp = `RESP_OKAY;
        default:         n.bresp = `RESP_SLVERR;
      endcase
    end

    // AXI4-Lite read path: one read in flight, answer one cycle later
    if (s.rvalid & rready) begin
      n.rvalid = 1'b0;
    end
    if (arvalid & ~s.rvalid) begin
      n.rvalid = 1'b1;
      n.rresp  = `RESP_OKAY;
      unique case (word_addr(araddr))
        `ADDR_CTRL:      n.rdata = s.cfg.ctrl;
        `ADDR_TOFF_DLY:  n.rdata = s.cfg.toff_dly;
        `ADDR_HOLD_DLY:  n.rdata = s.cfg.hold_dly;
        `ADDR_STILL_THR: n.rdata = s.cfg.still_thr;
        `ADDR_POS_ERR:   n.rdata = s.cfg.pos_err_max;
        `ADDR_TOL_WIN:   n.rdata = s.cfg.tol_win;
        `ADDR_STATUS:    n.rdata = {18'h00000, s.mode, s.fb_fault, s.estop,
                                    s.ready, s.standstill, s.brake_cmd,
                                    s.torque_off, s.s2[`PIN_CUT_B], s.s2[`PIN_CUT_A]};
        default: begin
          n.rdata = 32'h0000_0000;
          n.rresp = `RESP_SLVERR;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s                 <= '0;
      s.mode            <= ST_BOOT;
      s.s1              <= `PINS_IDLE;
      s.s2              <= `PINS_IDLE;
      s.s3              <= `PINS_IDLE;
      s.torque_off      <= 1'b1;
      s.cfg.ctrl        <= `RST_CTRL;
      s.cfg.toff_dly    <= `RST_TOFF_DLY;
      s.cfg.hold_dly    <= `RST_HOLD_DLY;
      s.cfg.still_thr   <= `RST_STILL_THR;
      s.cfg.pos_err_max <= `RST_POS_ERR;
      s.cfg.tol_win     <= `RST_TOL_WIN;
    end else begin
      s <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign awready                 = ~s.aw_full;
  assign wready                  = ~s.w_full;
  assign bvalid                  = s.bvalid;
  assign bresp                   = s.bresp;
  assign arready                 = ~s.rvalid;
  assign rvalid                  = s.rvalid;
  assign rdata                   = s.rdata;
  assign rresp                   = s.rresp;
  assign torque_off_feedback_out = s.torque_off;
  assign second_shutdown_out     = s.torque_off;
  assign ready_out               = s.ready;
  assign standstill_feedback_out = s.standstill;
  assign brake_command_out       = s.brake_cmd;
  assign emergency_ramp_out      = s.estop & s.brake_cmd;

endmodule // drive_safe_stop_sequencer

// ### dss_consts.svh
`ifndef DSS_CONSTS_SVH
`define DSS_CONSTS_SVH
// Register byte offsets
`define ADDR_CTRL      8'h00
`define ADDR_TOFF_DLY  8'h04
`define ADDR_HOLD_DLY  8'h08
`define ADDR_STILL_THR 8'h0c
`define ADDR_POS_ERR   8'h10
`define ADDR_TOL_WIN   8'h14
`define ADDR_STATUS    8'h18
// Control fields
`define CTRL_DRIVE_ACT 0
`define CTRL_RAMP_MON  1
`define CTRL_MASK      32'h0000_0003
// Reset values, delays in clock ticks
`define RST_CTRL       32'h0000_0003
`define RST_TOFF_DLY   32'h0000_c350
`define RST_HOLD_DLY   32'h0000_c350
`define RST_STILL_THR  32'h0000_0000
`define RST_POS_ERR    32'h0000_1000
`define RST_TOL_WIN    32'h0000_0100
// Start-up and readback timing
`define STARTUP_TICKS  8'h10
`define FB_TICKS       4'h4
// Pin positions in the sync vector
`define PIN_CUT_A      0
`define PIN_CUT_B      1
`define PIN_HOLD       2
`define PIN_SEVERE     3
`define PIN_ERR        4
`define PIN_RDBK       5
`define PINS_IDLE      6'h07
// AXI responses
`define RESP_OKAY      2'b00
`define RESP_SLVERR    2'b10
`endif

// ### dss_pkg.sv
package dss_pkg;
  typedef enum logic [5:0] {
    ST_BOOT = 6'b000001,
    ST_RUN  = 6'b000010,
    ST_CUT  = 6'b000100,
    ST_TOFF = 6'b001000,
    ST_HOLD = 6'b010000,
    ST_MON  = 6'b100000
  } mode_t;

  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] toff_dly;
    logic [31:0] hold_dly;
    logic [31:0] still_thr;
    logic [31:0] pos_err_max;
    logic [31:0] tol_win;
  } cfg_t;

  typedef struct packed {
    logic [15:0] speed;
    logic [31:0] position;
    logic [31:0] ramp_err;
  } amp_fb_t;

  typedef struct packed {
    mode_t       mode;
    logic [5:0]  s1;
    logic [5:0]  s2;
    logic [5:0]  s3;
    logic [31:0] timer;
    logic [7:0]  boot_cnt;
    logic [3:0]  fb_cnt;
    logic        fb_fault;
    logic        estop;
    logic [31:0] hold_pos;
    cfg_t        cfg;
    logic        aw_full;
    logic [7:0]  aw_addr;
    logic        w_full;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        torque_off;
    logic        brake_cmd;
    logic        standstill;
    logic        ready;
  } state_t;
endpackage

// ### dss_chk.sv
`timescale 1ns/1ps
module dss_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic cutoff_stop_request_in,
  input wire logic cutoff_stop_second_in,
  input wire logic severe_fault_in,
  input wire logic torque_off_feedback_out,
  input wire logic second_shutdown_out,
  input wire logic ready_out,
  input wire logic standstill_feedback_out,
  input wire logic brake_command_out
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Four low samples flush the sync chain, so no restart edge is still in flight
  sequence second_low;
    !cutoff_stop_second_in [*4];
  endsequence
  sequence both_low;
    !cutoff_stop_request_in && !cutoff_stop_second_in;
  endsequence
  a_shutdown_pair: assert property (second_shutdown_out == torque_off_feedback_out)
    else $error("shutdown pair differs");
  a_fault_cuts: assert property (severe_fault_in |-> ##[1:5] torque_off_feedback_out)
    else $error("fault left torque on");
  a_both_low_cut: assert property (both_low |-> ##[1:5] torque_off_feedback_out)
    else $error("both low left torque on");
  a_boot_not_ready: assert property ($rose(aresetn) |-> !ready_out [*8])
    else $error("ready during start-up");
  a_hold_powered: assert property (standstill_feedback_out |-> !torque_off_feedback_out)
    else $error("torque off while holding");
  a_brake_first: assert property (brake_command_out |-> !torque_off_feedback_out)
    else $error("brake with torque off");
  a_off_stays_off: assert property (
    second_low ##0 torque_off_feedback_out |=> torque_off_feedback_out
  ) else $error("left torque off without restart");
  a_cut_ends_hold: assert property (
    !cutoff_stop_request_in |-> ##[1:5] !standstill_feedback_out
  ) else $error("hold survived cutoff request");
endmodule // dss_chk

bind drive_safe_stop_sequencer dss_chk dss_chk_i (
  .aclk(aclk), .aresetn(aresetn), .cutoff_stop_request_in(cutoff_stop_request_in),
  .cutoff_stop_second_in(cutoff_stop_second_in), .severe_fault_in(severe_fault_in),
  .torque_off_feedback_out(torque_off_feedback_out), .second_shutdown_out(second_shutdown_out),
  .ready_out(ready_out), .standstill_feedback_out(standstill_feedback_out),
  .brake_command_out(brake_command_out)
);

// ### dss_amp_model.sv
`timescale 1ns/1ps
module amp_model
  import dss_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        brake_cmd,
  input  wire logic        ctl_brake,
  input  wire logic        torque_off,
  input  wire logic        hold,
  input  wire logic [31:0] ramp_err,
  input  wire logic        jolt,
  output amp_fb_t          fb = '0,
  output logic             readback = 1'b1
);
  // Coasts when torque-free; speed clamped to zero while standstill is held
  always @(posedge aclk) begin
    readback <= torque_off;
    fb.ramp_err <= ramp_err;
    fb.position <= fb.position + {16'h0000, fb.speed} + (jolt ? 32'h1000 : 32'h0);
    if (hold) begin
      fb.speed <= 16'h0000;
    end else if (brake_cmd || ctl_brake) begin
      fb.speed <= (fb.speed > 16'h0040) ? fb.speed - 16'h0040 : 16'h0000;
    end else if (!torque_off && fb.speed < 16'h0800) begin
      fb.speed <= fb.speed + 16'h0040;
    end
  end
endmodule // amp_model

// ### tb_top.sv
`timescale 1ns/1ps
`include "dss_consts.svh"
module tb_top;
  import dss_pkg::*;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rerr = 32'h0;
  logic [31:0] seed = 32'hdf78ce2b;
  logic [31:0] rdata, rdv, dly;
  logic [1:0]  bresp, rresp, rrs, bres;
  logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b1, rready = 1'b1;
  logic        cut_a = 1'b1, cut_b = 1'b1, hold = 1'b1, sev = 1'b0, err = 1'b0;
  logic        ctlb = 1'b0, jolt = 1'b0, b_seen;
  logic        awready, wready, bvalid, arready, rvalid, rdbk, toff, rdy, still, brk, eramp;
  amp_fb_t     fb;
  int          error_cnt = 0;
  int          total_checks = 0;
  int          n_off;
  logic [31:0] rst_val [6] = '{`RST_CTRL, `RST_TOFF_DLY, `RST_HOLD_DLY, `RST_STILL_THR,
                               `RST_POS_ERR, `RST_TOL_WIN};
  always #10 aclk = ~aclk;
  drive_safe_stop_sequencer drive_safe_stop_sequencer_i (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .cutoff_stop_request_in(cut_a), .cutoff_stop_second_in(cut_b),
    .hold_stop_request_in(hold), .severe_fault_in(sev), .stop_error_in(err),
    .torque_off_readback_in(rdbk), .amp_fb(fb), .torque_off_feedback_out(toff),
    .second_shutdown_out(), .ready_out(rdy), .standstill_feedback_out(still),
    .brake_command_out(brk), .emergency_ramp_out(eramp)
  );
  amp_model amp_model_i (
    .aclk(aclk), .brake_cmd(brk), .ctl_brake(ctlb), .torque_off(toff), .hold(still),
    .ramp_err(rerr), .jolt(jolt), .fb(fb), .readback(rdbk)
  );
  ////////////////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic lim(input int n, input int m);
    if (n >= m) begin
      error_cnt++;
      tally_and_finish();
    end
  endtask
  // Ready lines stay high; the slave may take address and data in either order
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (!bvalid && n < 40);
    bres = bresp;
    lim(n, 40);
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (!rvalid && n < 40);
    rdv = rdata;
    rrs = rresp;
    lim(n, 40);
  endtask
  task automatic wait_off(input int m);
    b_seen = 1'b0;
    for (n_off = 0; n_off < m && toff !== 1'b1; n_off++) begin
      @(posedge aclk);
      b_seen = b_seen | brk;
    end
    lim(n_off, m);
  endtask
  // Torque off first, then a rising second input restarts the drive
  task automatic run_ok;
    cut_a <= 1'b0;
    cut_b <= 1'b0;
    sev <= 1'b0;
    err <= 1'b0;
    rerr <= 32'h0;
    hold <= 1'b1;
    ctlb <= 1'b0;
    tick(6);
    chk(toff, 1'b1);
    cut_a <= 1'b1;
    tick(6);
    cut_b <= 1'b1;
    tick(50);
    chk(toff, 1'b0);
    chk(rdy, 1'b1);
    $display("test done at %0t", $time);
  endtask
  ////////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    tick(2);
    aresetn <= 1'b1;
    tick(2);
    chk(toff, 1'b1);
    chk(rdy, 1'b0);
    tick(40);
    chk({rdy, toff}, 2'b10);
    foreach (rst_val[i]) begin
      rd(8'(i * 4));
      chk(rdv, rst_val[i]);
    end
    rd(8'h1c);
    chk(rrs, `RESP_SLVERR);
    wr(8'h1c, seed);
    chk(bres, `RESP_SLVERR);
    seed = xs(seed);
    wr(`ADDR_TOL_WIN, seed);
    rd(`ADDR_TOL_WIN);
    chk(rdv, seed);
    wr(`ADDR_TOL_WIN, `RST_TOL_WIN);
    $display("test done at %0t", $time);
    for (int k = 0; k < 2; k++) begin
      seed = xs(seed);
      dly = 32'd8 + {28'h0, seed[3:0]};
      wr(`ADDR_TOFF_DLY, dly);
      cut_a <= (k != 0);
      cut_b <= (k == 0);
      wait_off(60);
      chk(b_seen, 1'b1);
      chk(n_off >= dly && n_off <= dly + 8, 1'b1);
      run_ok();
    end
    wr(`ADDR_TOFF_DLY, 32'h0);
    cut_a <= 1'b0;
    wait_off(10);
    chk(b_seen, 1'b0);
    run_ok();
    wr(`ADDR_TOFF_DLY, 32'd200);
    for (int k = 0; k < 5; k++) begin
      case (k)
        0: begin
          cut_a <= 1'b0;
          tick(10);
          cut_b <= 1'b0;
        end
        1: sev <= 1'b1;
        2: begin
          err <= 1'b1;
          tick(8);
          chk(eramp, 1'b1);
          err <= 1'b0;
          tick(2);
          err <= 1'b1;
        end
        3: begin
          cut_a <= 1'b0;
          tick(10);
          rerr <= `RST_POS_ERR + 32'h1;
        end
        default: begin
          // Just above one speed step, so the braking axis counts as standstill and ends the 200-tick cutoff delay early
          wr(`ADDR_STILL_THR, 32'h41);
          cut_a <= 1'b0;
        end
      endcase
      wait_off(k == 4 ? 50 : 10);
      chk(b_seen, k != 1);
      run_ok();
    end
    wr(`ADDR_HOLD_DLY, 32'd200);
    hold <= 1'b0;
    tick(8);
    chk(brk, 1'b1);
    for (n_off = 0; n_off < 60 && still !== 1'b1; n_off++) tick(1);
    lim(n_off, 60);
    chk({still, toff}, 2'b10);
    wr(`ADDR_STILL_THR, 32'h0);
    jolt <= 1'b1;
    tick(1);
    jolt <= 1'b0;
    tick(8);
    chk({still, eramp}, 2'b01);
    run_ok();
    wr(`ADDR_CTRL, 32'h0);
    cut_a <= 1'b0;
    ctlb <= 1'b1;
    wait_off(250);
    chk(b_seen, 1'b0);
    $display("test done at %0t", $time);
    tally_and_finish();
  end
endmodule // tb_top
